// ===== hdl/pd_pkg.sv
// Constants and types for the DRAM power-down and clock-change sequencer.
// Assumes the DRAM clock equals mclk (50 MHz); all timings become mclk cycles.
package pd_pkg;

    // Times held in units of 0.01 ns so that fractional figures stay exact
    localparam int TCK_CNS      = 2000;
    localparam int TCKE_CNS     = 750;
    localparam int TCKE_NCK     = 4;
    localparam int TCMDCKE_CNS  = 175;
    localparam int TCMDCKE_NCK  = 3;
    localparam int TCKELCK_CNS  = 500;
    localparam int TCKELCK_NCK  = 5;
    localparam int TCSCKE_CNS   = 175;
    localparam int TCKELCS_CNS  = 500;
    localparam int TCKELCS_NCK  = 5;
    localparam int TCKCKEH_CNS  = 175;
    localparam int TCKCKEH_NCK  = 3;
    localparam int TXP_CNS      = 750;
    localparam int TXP_NCK      = 5;
    localparam int TCSCKEH_CNS  = 175;
    localparam int TCKEHCS_CNS  = 750;
    localparam int TCKEHCS_NCK  = 5;
    localparam int TMRWCKEL_CNS = 1400;
    localparam int TMRWCKEL_NCK = 10;
    localparam int TZQCKE_CNS   = 175;
    localparam int TZQCKE_NCK   = 3;
    localparam int FREL_NCK     = 2;
    localparam int WAP_EXTRA    = 3;
    localparam int TW           = 10;

    // A delay expires only when both the time and the cycle count have passed
    function automatic int cyc(int cns, int nck);
        int c;
        c = (cns + TCK_CNS - 1) / TCK_CNS;
        return (c > nck) ? c : nck;
    endfunction : cyc

    function automatic int imax(int a, int b);
        return (a > b) ? a : b;
    endfunction : imax

    localparam int CKE_CYC    = cyc(TCKE_CNS, TCKE_NCK);
    localparam int CMDCKE_CYC = cyc(TCMDCKE_CNS, TCMDCKE_NCK);
    localparam int CSCKE_CYC  = cyc(TCSCKE_CNS, 1);
    localparam int LOWHOLD    = imax(cyc(TCKELCK_CNS, TCKELCK_NCK), cyc(TCKELCS_CNS, TCKELCS_NCK));
    localparam int CKCKEH_CYC = imax(cyc(TCKCKEH_CNS, TCKCKEH_NCK), cyc(TCSCKEH_CNS, 1));
    localparam int XP_CYC     = imax(cyc(TXP_CNS, TXP_NCK), cyc(TCKEHCS_CNS, TCKEHCS_NCK));
    localparam int MRWCKEL_CYC = cyc(TMRWCKEL_CNS, TMRWCKEL_NCK);
    localparam int ZQCKE_CYC  = cyc(TZQCKE_CNS, TZQCKE_NCK);

    typedef enum logic [2:0] {
        CMD_RD, CMD_WR, CMD_MWR, CMD_MRR, CMD_MRW, CMD_ZQ, CMD_OTHER
    } cmd_kind_t;

    typedef struct packed {
        cmd_kind_t kind;
        logic      ap;
    } cmd_t;

    typedef struct packed {
        logic [5:0] rl;
        logic [5:0] wl;
        logic [5:0] bl_half;
        logic [5:0] nwr;
        logic [5:0] twr;
        logic [5:0] tdqsck;
        logic [5:0] tdqss;
        logic [5:0] tdqs2dq;
        logic [7:0] mrw_extra;
        logic       read_postamble_select;
        logic [2:0] dq_odt_setting;
    } cfg_t;

    typedef struct packed {
        logic cke;
        logic cs;
        logic ck_run;
    } pins_t;

endpackage : pd_pkg

// ===== hdl/pd_ctrl.sv
// Host-side power-down, clock-stop and clock-change sequencer for a low-power DRAM.
// Assumes commands come in on mclk, DRAM clock = mclk gated by ck_run.
module pd_ctrl (
    input  wire logic     mclk,
    input  wire logic     rst,
    input  wire logic     cmd_valid,
    output logic          cmd_ready,
    input  pd_pkg::cmd_t  cmd_in,
    input  pd_pkg::cfg_t  cfg,
    input  wire logic     pd_req,
    input  wire logic     clk_stop_req,
    input  wire logic     fchg_req,
    output pd_pkg::cmd_t  cmd_out_r,
    output logic          cmd_issue_r,
    output pd_pkg::pins_t pins_r,
    output logic          in_pd_r,
    output logic          mrw_advise_r
);
    import pd_pkg::*;

    typedef enum logic [2:0] {
        S_ACT, S_ENTRY, S_PD, S_WAKE, S_XP, S_FCHG, S_FREL
    } state_t;

    state_t        state_r;
    state_t        state_nxt;
    logic [TW-1:0] wait_r;
    logic [TW-1:0] wait_nxt;
    logic [TW-1:0] tmr_r;
    logic [TW-1:0] tmr_nxt;
    logic [TW-1:0] pulse_r;
    logic [TW-1:0] pulse_nxt;
    logic [TW-1:0] dly;
    logic [TW-1:0] wbase;
    logic [TW-1:0] wdec;
    pins_t         pins_nxt;
    cmd_t          cmd_out_nxt;
    logic          issue_nxt;
    logic          in_pd_nxt;
    logic          advise_nxt;
    logic          accept;
    logic          idle_ok;

    // Earliest clock-enable fall after each command kind
    always_comb begin
        wbase = TW'(cfg.wl) + TW'(cfg.tdqss) + TW'(cfg.tdqs2dq) + TW'(cfg.bl_half);
        unique case (cmd_in.kind)
            CMD_RD, CMD_MRR: begin
                dly = TW'(cfg.rl) + TW'(cfg.tdqsck) + TW'(cfg.bl_half)
                    + (cfg.read_postamble_select ? TW'(2) : TW'(1));
            end
            // Termination setting deliberately not consulted
            CMD_WR, CMD_MWR: begin
                if (cmd_in.ap) begin
                    dly = wbase + TW'(cfg.nwr) + TW'(WAP_EXTRA);
                end else begin
                    dly = wbase + TW'(cfg.twr);
                end
            end
            CMD_MRW: begin
                dly = (TW'(cfg.mrw_extra) > TW'(MRWCKEL_CYC)) ?
                      TW'(cfg.mrw_extra) : TW'(MRWCKEL_CYC);
            end
            CMD_ZQ: begin
                dly = TW'(ZQCKE_CYC);
            end
            default: begin
                dly = TW'(CMDCKE_CYC);
            end
        endcase
    end

    // Commands only flow in normal operation and not while a change is asked for
    assign cmd_ready = (state_r == S_ACT) && !pd_req && !fchg_req;
    assign accept    = cmd_valid && cmd_ready;
    // Nothing outstanding: every data burst and command timing has run out
    // CS must sit low through the cycle before the fall as well
    assign idle_ok   = (wait_r == '0) && !cmd_valid && !pins_r.cs && !cmd_issue_r;

    // Deadline tracker: keeps the latest of all pending fall deadlines
    always_comb begin
        wdec = (wait_r != '0) ? (wait_r - TW'(1)) : wait_r;
        wait_nxt = wdec;
        if (accept && (dly > wdec)) begin
            wait_nxt = dly;
        end
    end

    always_comb begin
        state_nxt   = state_r;
        tmr_nxt     = (tmr_r != '0) ? (tmr_r - TW'(1)) : tmr_r;
        pins_nxt    = pins_r;
        pins_nxt.cs = accept;
        cmd_out_nxt = accept ? cmd_in : cmd_out_r;
        issue_nxt   = accept;
        advise_nxt  = 1'b0;
        unique case (state_r)
            S_ACT: begin
                if (pd_req && idle_ok && (pulse_r >= TW'(CKE_CYC - 1))) begin
                    state_nxt    = S_ENTRY;
                    pins_nxt.cke = 1'b0;
                    tmr_nxt      = TW'(LOWHOLD - 1);
                end else if (fchg_req && idle_ok) begin
                    state_nxt       = S_FCHG;
                    pins_nxt.ck_run = 1'b0;
                end
            end
            S_ENTRY: begin
                // Clock and CS held until the device has latched the fall
                pins_nxt.ck_run = 1'b1;
                if (tmr_r == '0) begin
                    state_nxt = S_PD;
                    pins_nxt.ck_run = !clk_stop_req;
                end
            end
            S_PD: begin
                // Clock may stop or change here; ZQ calibration carries on inside
                pins_nxt.ck_run = !clk_stop_req;
                if (!pd_req && (pulse_r >= TW'(CKE_CYC - 1))) begin
                    state_nxt       = S_WAKE;
                    pins_nxt.ck_run = 1'b1;
                    tmr_nxt         = TW'(CKCKEH_CYC - 1);
                end
            end
            S_WAKE: begin
                if (tmr_r == '0) begin
                    state_nxt    = S_XP;
                    pins_nxt.cke = 1'b1;
                    tmr_nxt      = TW'(XP_CYC - 1);
                end
            end
            S_XP: begin
                if (tmr_r == '0) begin
                    state_nxt = S_ACT;
                end
            end
            S_FCHG: begin
                if (!fchg_req) begin
                    state_nxt       = S_FREL;
                    pins_nxt.ck_run = 1'b1;
                    tmr_nxt         = TW'(FREL_NCK + XP_CYC - 1);
                end
            end
            S_FREL: begin
                if (tmr_r == '0) begin
                    state_nxt  = S_ACT;
                    advise_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = S_ACT;
            end
        endcase
        in_pd_nxt = (state_nxt == S_ENTRY) || (state_nxt == S_PD) || (state_nxt == S_WAKE);
        // Pulse-width counter restarts on every clock-enable edge
        if (pins_nxt.cke != pins_r.cke) begin
            pulse_nxt = '0;
        end else if (pulse_r != '1) begin
            pulse_nxt = pulse_r + TW'(1);
        end else begin
            pulse_nxt = pulse_r;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r      <= S_ACT;
            wait_r       <= '0;
            tmr_r        <= '0;
            pulse_r      <= '0;
            pins_r       <= '{cke: 1'b1, cs: 1'b0, ck_run: 1'b1};
            cmd_out_r    <= '{kind: CMD_OTHER, ap: 1'b0};
            cmd_issue_r  <= 1'b0;
            in_pd_r      <= 1'b0;
            mrw_advise_r <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            wait_r       <= wait_nxt;
            tmr_r        <= tmr_nxt;
            pulse_r      <= pulse_nxt;
            pins_r       <= pins_nxt;
            cmd_out_r    <= cmd_out_nxt;
            cmd_issue_r  <= issue_nxt;
            in_pd_r      <= in_pd_nxt;
            mrw_advise_r <= advise_nxt;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    deadline_met_a: assert property ($fell(pins_r.cke) |-> $past(wait_r) == '0)
        else $error("clock-enable fell before command deadline");
    low_width_a: assert property ($fell(pins_r.cke) |-> !pins_r.cke [*4])
        else $error("clock-enable low pulse too short");
    high_width_a: assert property ($rose(pins_r.cke) |-> pins_r.cke [*4])
        else $error("clock-enable high pulse too short");
    clk_after_fall_a: assert property ($fell(pins_r.cke) |-> pins_r.ck_run [*5])
        else $error("clock stopped too soon after entry");
    cs_after_fall_a: assert property ($fell(pins_r.cke) |-> !pins_r.cs [*5])
        else $error("CS not held after entry");
    clk_before_rise_a: assert property ($rose(pins_r.cke) |->
        $past(pins_r.ck_run, 1) && $past(pins_r.ck_run, 2) && $past(pins_r.ck_run, 3))
        else $error("clock not stable before exit");
    xp_gap_a: assert property ($rose(pins_r.cke) |-> !cmd_issue_r [*5])
        else $error("command issued inside exit latency");
    cs_after_rise_a: assert property ($rose(pins_r.cke) |-> !pins_r.cs [*5])
        else $error("CS not held after exit");
    mrw_hold_a: assert property ((cmd_issue_r && cmd_out_r.kind == CMD_MRW) |->
        wait_r >= TW'(MRWCKEL_CYC - 1))
        else $error("mode register write wait too short");
    fchg_pins_a: assert property ((state_r == S_FCHG) |-> pins_r.cke && !pins_r.cs)
        else $error("clock change without CS low and clock-enable high");
    frel_wait_a: assert property ($rose(pins_r.ck_run) && pins_r.cke |-> !cmd_issue_r [*7])
        else $error("command too soon after clock change");

    // Pin, counter and handshake invariants that the timers above rely on
    cs_issue_a: assert property (pins_r.cs == cmd_issue_r)
        else $error("CS high outside an issue cycle");
    cs_before_fall_a: assert property ($fell(pins_r.cke) |-> !$past(pins_r.cs))
        else $error("CS not low before entry");
    no_cmd_low_a: assert property (!pins_r.cke |-> !cmd_issue_r)
        else $error("command issued with clock-enable low");
    pd_flag_a: assert property (in_pd_r == !pins_r.cke)
        else $error("power-down flag disagrees with clock-enable");
    stop_states_a: assert property (!pins_r.ck_run |-> (state_r == S_PD || state_r == S_FCHG))
        else $error("clock stopped outside power-down or clock change");
    exit_clock_a: assert property ($rose(pins_r.cke) |-> pins_r.ck_run && $past(state_r) == S_WAKE)
        else $error("exit without a running clock");
    pd_quiet_a: assert property ((state_r == S_PD || state_r == S_WAKE) |-> !pins_r.cs)
        else $error("CS high during power-down");
    fchg_idle_a: assert property ($fell(pins_r.ck_run) && pins_r.cke |-> $past(wait_r) == '0)
        else $error("clock change started with work outstanding");
    zq_hold_a: assert property ((cmd_issue_r && cmd_out_r.kind == CMD_ZQ) |->
        wait_r >= TW'(ZQCKE_CYC - 1))
        else $error("ZQ start wait too short");
    cmd_hold_a: assert property ((cmd_issue_r && cmd_out_r.kind == CMD_OTHER) |->
        wait_r >= TW'(CMDCKE_CYC - 1))
        else $error("command wait too short");
    wait_count_a: assert property ((wait_r != '0) && !accept |=> wait_r == $past(wait_r) - TW'(1))
        else $error("deadline counter did not count down");
    issue_echo_a: assert property (accept |=> cmd_issue_r && cmd_out_r == $past(cmd_in))
        else $error("accepted command not issued next cycle");
    advise_end_a: assert property (mrw_advise_r |-> $past(state_r) == S_FREL)
        else $error("settings advice outside clock-change end");

    pd_trip_c: cover property ($fell(pins_r.cke) ##[1:100] $rose(pins_r.cke));
    pd_stop_c: cover property (in_pd_r && !pins_r.ck_run);
    fchg_c: cover property (mrw_advise_r);
    b2b_c: cover property (cmd_issue_r ##1 cmd_issue_r);
    rd_pd_c: cover property (cmd_issue_r && cmd_out_r.kind == CMD_RD ##[1:200] $fell(pins_r.cke));

endmodule : pd_ctrl

// ===== test/pd_dram_model.sv
// Behavioural device model that watches the controller's clock-enable, CS and clock-gate pins.
// Assumes pins change only on mclk rising edges; counts pulse-width, clock, CS and exit-latency breaches in viol.
module pd_dram_model (
    input  wire logic     mclk,
    input  wire logic     rst,
    input  pd_pkg::pins_t pins,
    input  wire logic     issue,
    input  pd_pkg::cmd_t  cmd,
    output int            viol,
    output logic          in_pd
);
    timeunit 1ns;
    timeprecision 1ps;
    import pd_pkg::*;

    // Calibration length is arbitrary; it only has to outlast short power-down stays
    localparam int ZQ_CAL_CYC = 40;

    logic cke_q;
    logic pd_seen;
    int   lvl;
    int   run;
    int   n;
    int   zq_left;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cke_q = 1'b1;
            pd_seen = 1'b0;
            lvl = 0;
            run = 0;
            viol = 0;
            in_pd = 1'b0;
            zq_left = 0;
        end else begin
            n = (pins.cke == cke_q) ? lvl + 1 : 1;
            in_pd = !pins.cke;
            // Calibration keeps running whatever clock-enable does
            if (issue && cmd.kind == CMD_ZQ) zq_left = ZQ_CAL_CYC;
            else if (zq_left > 0) zq_left = zq_left - 1;
            if (pins.cke != cke_q && lvl < 4) viol++;
            if (pins.cke && !cke_q && run < 3) viol++;
            if (!pins.cke && n <= 5 && (!pins.ck_run || pins.cs)) viol++;
            if (pins.cke && pd_seen && n <= 5 && issue) viol++;
            if (pins.cke && !pins.ck_run && pins.cs) viol++;
            if (!pins.cke && issue) viol++;
            pd_seen = pd_seen | !pins.cke;
            cke_q = pins.cke;
            lvl = n;
            run = pins.ck_run ? run + 1 : 0;
        end
    end
endmodule : pd_dram_model

// ===== test/dram_power_down_clock_change_timing_tb.sv
// Self-checking bench for the power-down and clock-change sequencer.
// Assumes pd_pkg and pd_ctrl are compiled first; inputs change on falling edges.
module dram_power_down_clock_change_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pd_pkg::*;

    logic  mclk, rst, cmd_valid, cmd_ready, pd_req, clk_stop_req, fchg_req;
    logic  cmd_issue_r, in_pd_r, mrw_advise_r, dev_pd, cke_p, run_p;
    cmd_t  cmd_in, cmd_out_r, c;
    cfg_t  cfg;
    pins_t pins_r;
    int    err_count, comparisons, seed, cyc_n, viol, deadline, last_iss, rise_c, run_c, adv_c, t;
    cmd_t  sent_q[$];
    int    acc_q[$];

    pd_ctrl uut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_in(cmd_in),
        .cfg(cfg), .pd_req(pd_req), .clk_stop_req(clk_stop_req), .fchg_req(fchg_req), .cmd_out_r(cmd_out_r),
        .cmd_issue_r(cmd_issue_r), .pins_r(pins_r), .in_pd_r(in_pd_r), .mrw_advise_r(mrw_advise_r));

    pd_dram_model dev (.mclk(mclk), .rst(rst), .pins(pins_r), .issue(cmd_issue_r), .cmd(cmd_out_r),
        .viol(viol), .in_pd(dev_pd));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) cyc_n <= cyc_n + 1;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    function automatic int rnd(int n);
        return {$random(seed)} % n;
    endfunction : rnd

    function automatic cmd_t rcmd(int k);
        cmd_t r;
        r.kind = cmd_kind_t'(3'(k));
        r.ap = 1'(rnd(2));
        return r;
    endfunction : rcmd

    // Earliest clock-enable fall after a command, less one, in cycles past its issue cycle
    function automatic int dly(cmd_t k);
        case (k.kind)
            CMD_RD, CMD_MRR: return 0 + cfg.rl + cfg.tdqsck + cfg.bl_half + (cfg.read_postamble_select ? 2 : 1);
            CMD_WR, CMD_MWR: return 0 + cfg.wl + cfg.tdqss + cfg.tdqs2dq + cfg.bl_half + (k.ap ? cfg.nwr + 3 : cfg.twr);
            CMD_MRW: return (cfg.mrw_extra > 10) ? 0 + cfg.mrw_extra : 10;
            default: return 3;
        endcase
    endfunction : dly

    // Deadline is kept as the latest fall point over every issued command
    always @(negedge mclk) begin
        if (cmd_issue_r === 1'b1 && sent_q.size() > 0) begin
            c = sent_q.pop_front();
            chk("cmd_out", c, cmd_out_r);
            chk("issue lag", acc_q.pop_front() + 1, cyc_n);
            if (cyc_n + dly(c) + 1 > deadline) deadline = cyc_n + dly(c) + 1;
            last_iss = cyc_n;
        end
        if (pins_r.cke === 1'b1 && !cke_p) rise_c = cyc_n;
        if (pins_r.ck_run === 1'b1 && !run_p) run_c = cyc_n;
        if (mrw_advise_r === 1'b1) adv_c = cyc_n;
        chk("model pd", !cke_p, dev_pd);
        cke_p = pins_r.cke;
        run_p = pins_r.ck_run;
    end

    task automatic send(cmd_t k);
        int w;
        cmd_in = k;
        cmd_valid = 1'b1;
        w = 0;
        while (cmd_ready !== 1'b1 && w < 500) begin
            @(negedge mclk);
            w++;
        end
        chk("ready", 1, cmd_ready);
        acc_q.push_back(cyc_n);
        sent_q.push_back(k);
        @(negedge mclk);
    endtask : send

    initial begin
        #1ms;
        err_count++;
        $display("BAD watchdog expected finish seen timeout");
        report_and_stop();
    end

    initial begin
        seed = 84;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_in = '0;
        pd_req = 1'b0;
        clk_stop_req = 1'b0;
        fchg_req = 1'b0;
        cfg = '0;
        cke_p = 1'b1;
        run_p = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        chk("reset pins", 3'b101, pins_r);
        chk("reset in_pd", 0, in_pd_r);
        for (int i = 0; i < 16; i++) begin
            cfg = cfg_t'({6'(4 + rnd(20)), 6'(4 + rnd(20)), 6'(4 + rnd(12)), 6'(4 + rnd(20)), 6'(2 + rnd(20)),
                6'(rnd(8)), 6'(rnd(4)), 6'(rnd(4)), 8'(rnd(30)), 1'(rnd(2)), 3'(rnd(8))});
            send(rcmd(i < 7 ? i : rnd(7)));
            if (i >= 7) send(rcmd(rnd(7)));
            cmd_valid = 1'b0;
            pd_req = 1'b1;
            t = 0;
            while (pins_r.cke !== 1'b0 && t < 600) begin
                @(negedge mclk);
                t++;
            end
            chk("cke fall", deadline, cyc_n);
            chk("in_pd", 1, in_pd_r);
            clk_stop_req = 1'(rnd(2));
            repeat (rnd(14)) @(negedge mclk);
            if (cyc_n >= deadline + 6) chk("ck_run in pd", !clk_stop_req, pins_r.ck_run);
            pd_req = 1'b0;
            send(rcmd(rnd(7)));
            cmd_valid = 1'b0;
            @(negedge mclk);
            chk("exit to issue", rise_c + 6, last_iss);
            if (i % 4 == 3) begin
                fchg_req = 1'b1;
                t = 0;
                while (pins_r.ck_run !== 1'b0 && t < 300) begin
                    @(negedge mclk);
                    t++;
                end
                chk("cke in clock change", 1, pins_r.cke);
                repeat (2 + rnd(8)) @(negedge mclk);
                fchg_req = 1'b0;
                send(rcmd(rnd(7)));
                cmd_valid = 1'b0;
                @(negedge mclk);
                chk("restart to advise", run_c + 7, adv_c);
                chk("advise before issue", 1, last_iss > adv_c);
            end
        end
        chk("device violations", 0, viol);
        report_and_stop();
    end
endmodule : dram_power_down_clock_change_timing_tb
